// ### design/exp_host.sv
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "exp_cfg.svh"

module exp_host (
  // System
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial link
  i2c_if.host link
);

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  logic [3:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [7:0] cmd_byte;
  logic [7:0] wr_byte;
  logic rd_op;
  logic [1:0] sel;
  logic brst;
  logic bus_reset_n;
  logic busy;
  logic nack;
  logic done;
  logic [7:0] rx_data;

  wire wr_fire = ~awready & ~wready & ~bvalid;
  wire wr_cmd = wr_fire & (wa == `REG_CMD);
  wire wr_brst = wr_fire & (wa == `REG_BRST);
  wire wr_ok = wr_cmd | wr_brst | (wa == `REG_STAT);
  // A command written while busy is dropped rather than queued
  wire go = wr_cmd & (ws[2:0] == 3'h7) & ~busy;
  wire [31:0] rd_word = (araddr == `REG_CMD) ? {13'h0000, sel, rd_op, wr_byte, cmd_byte} :
                        (araddr == `REG_STAT) ? {21'h000000, done, nack, busy, rx_data} :
                        (araddr == `REG_BRST) ? {31'h00000000, brst} : 32'h00000000;
  wire rd_ok = (araddr == `REG_CMD) | (araddr == `REG_STAT) | (araddr == `REG_BRST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
      wa <= 4'h0;
      wd <= 32'h00000000;
      ws <= 4'h0;
      cmd_byte <= 8'h00;
      wr_byte <= 8'h00;
      rd_op <= 1'b0;
      sel <= 2'h0;
      brst <= 1'b0;
      bus_reset_n <= 1'b1;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wa <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wd <= wdata;
        ws <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (go) begin
        cmd_byte <= wd[7:0];
        wr_byte <= wd[15:8];
        rd_op <= wd[16];
        sel <= wd[18:17];
      end
      if (wr_brst && ws[0]) begin
        brst <= wd[0];
      end
      bus_reset_n <= ~brst;
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial master

  exp_pkg::host_state_t hstate;
  logic [7:0] qcnt;
  logic [1:0] qph;
  logic [1:0] bidx;
  logic [3:0] bitn;
  logic [7:0] txsh;
  logic [7:0] rxsh;
  logic scl;
  logic sda_oen;
  logic sda_s;
  logic [7:0] seq [0:3];

  exp_sync #(.W(1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(link.sda),
    .q(sda_s)
  );

  // Write: addr+W, command, data. Read: addr+W, command, restart, addr+R, one byte
  assign seq[0] = {`ADDR_UPPER, sel, 1'b0};
  assign seq[1] = cmd_byte;
  assign seq[2] = rd_op ? {`ADDR_UPPER, sel, 1'b1} : wr_byte;
  assign seq[3] = 8'hFF;
  wire [1:0] last_idx = rd_op ? 2'h3 : 2'h2;
  wire rx_byte = rd_op & (bidx == 2'h3);
  wire tick = qcnt == 8'(`QTR_CYC - 1);
  wire [1:0] bidx_nx = bidx + 2'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hstate <= exp_pkg::H_IDLE;
      qcnt <= 8'h00;
      qph <= 2'h0;
      bidx <= 2'h0;
      bitn <= 4'h0;
      txsh <= 8'hFF;
      rxsh <= 8'h00;
      scl <= 1'b1;
      sda_oen <= 1'b1;
      busy <= 1'b0;
      nack <= 1'b0;
      done <= 1'b0;
      rx_data <= 8'h00;
    end else if (hstate == exp_pkg::H_IDLE) begin
      if (go) begin
        hstate <= exp_pkg::H_START;
        qcnt <= 8'h00;
        qph <= 2'h0;
        bidx <= 2'h0;
        nack <= 1'b0;
        busy <= 1'b1;
        done <= 1'b0;
      end
    end else begin
      qcnt <= tick ? 8'h00 : qcnt + 8'h01;
      if (tick) begin
        qph <= qph + 2'h1;
        case (hstate)
          exp_pkg::H_START: begin
            case (qph)
              2'h0: sda_oen <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: sda_oen <= 1'b0;
              default: begin
                scl <= 1'b0;
                bitn <= 4'h0;
                txsh <= seq[bidx];
                hstate <= exp_pkg::H_BIT;
              end
            endcase
          end
          exp_pkg::H_BIT: begin
            case (qph)
              // Ninth bit is released: sample device ack, or leave read byte unacked
              2'h0: sda_oen <= (bitn == `BIT_ACK) | txsh[7];
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (bitn == `BIT_ACK) begin
                  if (!rx_byte && sda_s) begin
                    nack <= 1'b1;
                  end
                end else begin
                  rxsh <= {rxsh[6:0], sda_s};
                end
              end
              default: begin
                scl <= 1'b0;
                txsh <= {txsh[6:0], 1'b1};
                bitn <= bitn + 4'h1;
                if (bitn == `BIT_ACK) begin
                  bitn <= 4'h0;
                  if (nack || bidx == last_idx) begin
                    hstate <= exp_pkg::H_STOP;
                  end else begin
                    bidx <= bidx_nx;
                    txsh <= seq[bidx_nx];
                    if (rd_op && bidx == 2'h1) begin
                      hstate <= exp_pkg::H_START;
                    end
                  end
                end
              end
            endcase
          end
          exp_pkg::H_STOP: begin
            case (qph)
              2'h0: sda_oen <= 1'b0;
              2'h1: scl <= 1'b1;
              2'h2: sda_oen <= 1'b1;
              default: begin
                hstate <= exp_pkg::H_IDLE;
                busy <= 1'b0;
                done <= 1'b1;
                if (rd_op && !nack) begin
                  rx_data <= rxsh;
                end
              end
            endcase
          end
          default: hstate <= exp_pkg::H_IDLE;
        endcase
      end
    end
  end

  assign link.scl = scl;
  assign link.sda_host_oen = sda_oen;
  assign link.bus_reset_n = bus_reset_n;

endmodule // exp_host

// ### inc/exp_cfg.svh
`ifndef EXP_CFG_SVH
`define EXP_CFG_SVH

// Upper five slave address bits; value is arbitrary
`define ADDR_UPPER 5'h0C

// Command byte codes
`define CMD_IN_A 8'h00
`define CMD_IN_B 8'h01
`define CMD_OUT_A 8'h02
`define CMD_OUT_B 8'h03
`define CMD_CFG_A 8'h04
`define CMD_CFG_B 8'h05
`define CMD_MSK_A 8'h06
`define CMD_MSK_B 8'h07

// Serial framing counts and power-up init counts
`define BIT_ACK 4'h8
`define BIT_TX_LAST 4'h7
`define INIT_LOAD 2'h2
`define INIT_DONE 2'h3

// Link timing
`define CLK_PERIOD_NS 10
`define SCL_PERIOD_NS 200
`define QTR_CYC (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))

// Controller register map (byte addresses)
`define REG_CMD 4'h0
`define REG_STAT 4'h4
`define REG_BRST 4'h8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### inc/exp_pkg.sv
package exp_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_ADDR = 3'h1,
    D_RX = 3'h3,
    D_ACK = 3'h2,
    D_TX = 3'h6,
    D_MACK = 3'h7
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h3,
    H_STOP = 2'h2
  } host_state_t;
endpackage

// ### inc/i2c_if.sv
`timescale 1ns/1ps
interface i2c_if;
  logic scl;
  logic sda_host_oen;
  logic sda_dev_oen;
  logic bus_reset_n;
  logic sda;

  // Open drain: line is low while either side enables its driver
  assign sda = sda_host_oen & sda_dev_oen;

  modport host (
    output scl,
    output sda_host_oen,
    output bus_reset_n,
    input sda
  );

  modport dev (
    input scl,
    input sda,
    input bus_reset_n,
    output sda_dev_oen
  );
endinterface

// ### design/exp_sync.sv
`timescale 1ns/1ps
module exp_sync #(
  parameter int W = 1
) (
  // System
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // exp_sync

// ### design/exp_device.sv
`timescale 1ns/1ps
`include "exp_cfg.svh"

module exp_device (
  // System
  input wire logic aclk,
  input wire logic aresetn,
  // Address straps
  input wire logic addr_sel0,
  input wire logic addr_sel1,
  // Open-drain port A
  input wire logic [7:0] open_drain_pins_i,
  output logic [7:0] open_drain_pins_o,
  output logic [7:0] open_drain_pins_oen,
  // Push-pull port B
  input wire logic [7:0] push_pull_pins_i,
  output logic [7:0] push_pull_pins_o,
  output logic [7:0] push_pull_pins_oen,
  // Latched alert
  output logic change_alert_n,
  // Serial link
  i2c_if.dev link
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [20:0] sync_q;
  logic scl_q;
  logic sda_q;

  exp_sync #(.W(21)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({link.bus_reset_n, link.sda, link.scl, addr_sel1, addr_sel0,
        push_pull_pins_i, open_drain_pins_i}),
    .q(sync_q)
  );

  wire [15:0] pins_s = sync_q[15:0];
  wire strap0 = sync_q[16];
  wire strap1 = sync_q[17];
  wire scl_s = sync_q[18];
  wire sda_s = sync_q[19];
  wire brst_n_s = sync_q[20];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine

  exp_pkg::dev_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] cmd;
  logic has_cmd;
  logic is_read;
  logic mack_ok;
  logic sda_oen;

  logic [7:0] out_a;
  logic [7:0] out_b;
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic [7:0] mask_a;
  logic [7:0] mask_b;
  logic [15:0] snap;
  logic [7:0] rd_regs [0:7];

  // Bus reset only touches the engine, never the alert path
  wire eng_rst = ~aresetn | ~brst_n_s;
  wire byte_in = bitcnt == `BIT_ACK;
  wire addr_hit = shreg[7:1] == {`ADDR_UPPER, strap1, strap0};
  wire addr_done = (state == exp_pkg::D_ADDR) & scl_fall & byte_in;
  wire snap_en = addr_done & addr_hit & shreg[0];
  wire rx_done = (state == exp_pkg::D_RX) & scl_fall & byte_in;
  wire wr_en = rx_done & has_cmd;

  // Input registers return the snapshot taken at address acknowledge
  assign rd_regs[0] = snap[7:0];
  assign rd_regs[1] = snap[15:8];
  assign rd_regs[2] = out_a;
  assign rd_regs[3] = out_b;
  assign rd_regs[4] = cfg_a;
  assign rd_regs[5] = cfg_b;
  assign rd_regs[6] = mask_a;
  assign rd_regs[7] = mask_b;
  wire [7:0] rd_byte = (cmd[7:3] == 5'h00) ? rd_regs[cmd[2:0]] : 8'h00;

  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      state <= exp_pkg::D_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      cmd <= 8'h00;
      has_cmd <= 1'b0;
      is_read <= 1'b0;
      mack_ok <= 1'b0;
      sda_oen <= 1'b1;
    end else if (start_cond) begin
      state <= exp_pkg::D_ADDR;
      bitcnt <= 4'h0;
      has_cmd <= 1'b0;
      sda_oen <= 1'b1;
    end else if (stop_cond) begin
      state <= exp_pkg::D_IDLE;
      sda_oen <= 1'b1;
    end else begin
      case (state)
        exp_pkg::D_ADDR, exp_pkg::D_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && byte_in) begin
            bitcnt <= 4'h0;
            if (state == exp_pkg::D_ADDR && !addr_hit) begin
              state <= exp_pkg::D_IDLE;
            end else begin
              sda_oen <= 1'b0;
              state <= exp_pkg::D_ACK;
            end
            if (state == exp_pkg::D_ADDR) begin
              is_read <= shreg[0];
            end
            if (state == exp_pkg::D_RX && !has_cmd) begin
              cmd <= shreg;
              has_cmd <= 1'b1;
            end
          end
        end
        exp_pkg::D_ACK: begin
          if (scl_fall) begin
            if (is_read) begin
              state <= exp_pkg::D_TX;
              txreg <= rd_byte;
              sda_oen <= rd_byte[7];
            end else begin
              state <= exp_pkg::D_RX;
              sda_oen <= 1'b1;
            end
          end
        end
        exp_pkg::D_TX: begin
          if (scl_fall) begin
            if (bitcnt == `BIT_TX_LAST) begin
              sda_oen <= 1'b1;
              bitcnt <= 4'h0;
              state <= exp_pkg::D_MACK;
            end else begin
              txreg <= {txreg[6:0], 1'b0};
              sda_oen <= txreg[6];
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        exp_pkg::D_MACK: begin
          if (scl_rise) begin
            mack_ok <= ~sda_s;
          end else if (scl_fall) begin
            if (mack_ok) begin
              state <= exp_pkg::D_TX;
              txreg <= rd_byte;
              sda_oen <= rd_byte[7];
            end else begin
              state <= exp_pkg::D_IDLE;
            end
          end
        end
        default: begin
          state <= exp_pkg::D_IDLE;
        end
      endcase
    end
  end

  assign link.sda_dev_oen = sda_oen;

  ////////////////////////////////////////////////////////////////////////////
  // Port registers and transition detection

  logic [1:0] init_cnt;
  logic [15:0] ref_lvl;
  logic [15:0] flag;

  // Each strap drives one nibble of both ports
  wire [7:0] strap_dflt = {{4{strap1}}, {4{strap0}}};
  wire [15:0] is_in = {cfg_b, cfg_a};
  wire [15:0] mon = is_in & ~{mask_b, mask_a};
  wire clr_a = snap_en & (cmd == `CMD_IN_A);
  wire clr_b = snap_en & (cmd == `CMD_IN_B);
  wire [15:0] clr = {{8{clr_b}}, {8{clr_a}}};
  wire [15:0] hold = mon & ~clr;
  // Unwatched pins track the pad so unmasking never fires on changes made while unwatched
  wire [15:0] next_ref = (hold & ref_lvl) | (~hold & pins_s);
  wire [15:0] next_flag = (hold & (pins_s ^ ref_lvl)) | (flag & ~clr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_cnt <= 2'h0;
      out_a <= 8'h00;
      out_b <= 8'h00;
      cfg_a <= 8'h00;
      cfg_b <= 8'h00;
      mask_a <= 8'h00;
      mask_b <= 8'h00;
      snap <= 16'h0000;
      ref_lvl <= 16'h0000;
      flag <= 16'h0000;
      change_alert_n <= 1'b1;
      open_drain_pins_o <= 8'h00;
      open_drain_pins_oen <= 8'hFF;
      push_pull_pins_o <= 8'h00;
      push_pull_pins_oen <= 8'hFF;
    end else begin
      if (init_cnt != `INIT_DONE) begin
        init_cnt <= init_cnt + 2'h1;
      end
      // Straps pass the synchroniser before they are trusted
      if (init_cnt == `INIT_LOAD) begin
        out_a <= strap_dflt;
        out_b <= strap_dflt;
      end else if (wr_en) begin
        case (cmd)
          `CMD_OUT_A: out_a <= shreg;
          `CMD_OUT_B: out_b <= shreg;
          `CMD_CFG_A: cfg_a <= shreg;
          `CMD_CFG_B: cfg_b <= shreg;
          `CMD_MSK_A: mask_a <= shreg;
          `CMD_MSK_B: mask_b <= shreg;
          default: ;
        endcase
      end
      if (snap_en) begin
        snap <= pins_s;
      end
      ref_lvl <= next_ref;
      flag <= next_flag;
      change_alert_n <= ~|(next_flag & mon);
      open_drain_pins_o <= 8'h00;
      open_drain_pins_oen <= cfg_a | out_a;
      push_pull_pins_o <= out_b;
      push_pull_pins_oen <= cfg_b;
    end
  end

endmodule // exp_device

// ### test/exp_link_props.sv
`timescale 1ns/1ps
`include "exp_cfg.svh"

module exp_link_props (
  // System
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oen,
  input wire logic sda_dev_oen,
  input wire logic bus_reset_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////
  // Counts SCL rises since the last START; rise 9 is the ack slot
  logic scl_q;
  logic sda_q;
  logic rw;
  logic [3:0] bitcnt;
  logic [3:0] bytecnt;
  logic [7:0] sh;
  wire start_ev = scl && scl_q && sda_q && !sda;
  wire rise_ev = scl && !scl_q;
  wire hi = scl && scl_q;
  // Host release on read data bits is judged at the SCL fall: the rise that opens a stop or
  // restart also counts as bit one, but the host then holds SDA low
  wire fall_ev = !scl && scl_q;
  wire data_bit = (bitcnt != 4'h0) && (bitcnt != 4'h9);
  wire dev_tx = (bytecnt != 4'h0) && rw;
  wire ack_slot = hi && (bitcnt == 4'h9);

  always_ff @(posedge aclk) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start_ev) begin
      bitcnt <= 4'h0;
      bytecnt <= 4'h0;
    end else if (rise_ev) begin
      bitcnt <= (bitcnt == 4'h9) ? 4'h1 : bitcnt + 4'h1;
      bytecnt <= (bitcnt == 4'h9) ? bytecnt + 4'h1 : bytecnt;
    end
  end

  // Ack bit is not shifted, so sh holds the whole byte during its ack
  always_ff @(posedge aclk) begin
    if (rise_ev && bitcnt != 4'h8) begin
      sh <= {sh[6:0], sda};
    end
    if (rise_ev && bitcnt == 4'h7 && bytecnt == 4'h0) begin
      rw <= sda;
    end
  end

  ////////////////////////////////////////////////////////////
  sequence s_start;
    $fell(sda) && scl && $past(scl);
  endsequence
  sequence s_stop;
    $rose(sda) && scl && $past(scl);
  endsequence
  sequence s_brst_held;
    !bus_reset_n [*6];
  endsequence

  chk_start_by_host: assert property (s_start |-> !sda_host_oen)
    else $error("SDA fell under high SCL without the host");
  chk_stop_release: assert property (s_stop |=> sda_dev_oen [*4])
    else $error("device drives SDA after stop");
  // Bus reset may release SDA mid-bit, so that window is left out
  chk_dev_stable: assert property (hi && bus_reset_n && $past(bus_reset_n, 4) |->
    $stable(sda_dev_oen))
    else $error("device moved SDA while SCL high");
  chk_dev_quiet: assert property (hi && data_bit && !dev_tx |-> sda_dev_oen)
    else $error("device drove a data bit it should receive");
  chk_host_rd_release: assert property (fall_ev && data_bit && dev_tx |-> sda_host_oen)
    else $error("host drove SDA during read data");
  chk_host_ack_slot: assert property (ack_slot |-> sda_host_oen)
    else $error("host drove SDA in ack slot");
  chk_ack_addr_match: assert property (ack_slot && bytecnt == 4'h0 && !sda_dev_oen |->
    sh[7:3] == `ADDR_UPPER)
    else $error("device acked a foreign address");
  chk_brst_release: assert property (s_brst_held |-> sda_dev_oen)
    else $error("device holds SDA in bus reset");
endmodule // exp_link_props

// ### test/i2c_io_expander_16bit_bench.sv
`timescale 1ns/1ps
`include "exp_cfg.svh"

module i2c_io_expander_16bit_bench;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic [7:0] want;
  } row_t;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [7:0] ext_a = 8'hFF;
  logic [7:0] ext_b = 8'hFF;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, change_alert_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] od_o, od_oen, pp_o, pp_oen;
  // Pad levels: released pins follow the outside world
  wire [7:0] pad_a = ext_a & od_oen;
  wire [7:0] pad_b = (pp_oen & ext_b) | (~pp_oen & pp_o);
  int fail_count = 0;
  int checked = 0;
  row_t rows [9] = '{'{8'h04, 8'hFF, 8'hFF}, '{8'h05, 8'h0F, 8'h0F}, '{8'h06, 8'h00, 8'h00},
    '{8'h07, 8'hF0, 8'hF0}, '{8'h02, 8'h33, 8'h33}, '{8'h03, 8'hA5, 8'hA5},
    '{8'h00, 8'h5A, 8'h3C}, '{8'h01, 8'h5A, 8'hAC}, '{8'h08, 8'h77, 8'h00}};

  i2c_if link ();
  exp_host u_exp_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(link));
  exp_device u_exp_device (.aclk(aclk), .aresetn(aresetn), .addr_sel0(strap[0]),
    .addr_sel1(strap[1]), .open_drain_pins_i(pad_a), .open_drain_pins_o(od_o),
    .open_drain_pins_oen(od_oen), .push_pull_pins_i(pad_b), .push_pull_pins_o(pp_o),
    .push_pull_pins_oen(pp_oen), .change_alert_n(change_alert_n), .link(link));
  exp_link_props u_exp_link_props (.aclk(aclk), .aresetn(aresetn), .scl(link.scl),
    .sda(link.sda), .sda_host_oen(link.sda_host_oen), .sda_dev_oen(link.sda_dev_oen),
    .bus_reset_n(link.bus_reset_n));

  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    checked++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic note(input string what);
    $display("test %s finished", what);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] st);
    @(posedge aclk);
    strap <= st;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle budget here: only the watchdog ends a hung handshake
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // One serial transaction, then poll status until done and not busy
  task automatic xfer(input logic rd, input logic [1:0] st, input logic [7:0] cmd,
      input logic [7:0] dat, output logic [31:0] s);
    logic [1:0] r;
    axi_wr(`REG_CMD, {13'h0, st, rd, dat, cmd}, r);
    do begin
      axi_rd(`REG_STAT, s, r);
    end while (!(s[10] && !s[8]));
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] s;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0]);
      check(pp_o, {{4{i[1]}}, {4{i[0]}}}, "pp default");
      check(od_oen, {{4{i[1]}}, {4{i[0]}}}, "od default");
      check({pp_oen, change_alert_n}, 9'h001, "dir and alert");
    end
    note("defaults");
    do_reset(2'h1);
    ext_a <= 8'h3C;
    ext_b <= 8'h3C;
    foreach (rows[j]) begin
      xfer(1'b0, 2'h1, rows[j].cmd, rows[j].data, s);
      xfer(1'b1, 2'h1, rows[j].cmd, 8'h00, s);
      check(s[9:0], {2'h0, rows[j].want}, "readback");
    end
    check({od_o, od_oen, pp_oen, pp_o}, 32'h00FF0FA5, "pin drive");
    note("registers");
    xfer(1'b1, 2'h1, 8'h00, 8'h00, s);
    xfer(1'b1, 2'h1, 8'h01, 8'h00, s);
    xfer(1'b0, 2'h1, 8'h03, 8'h5A, s);
    check({pp_o, change_alert_n}, 9'h0B5, "output write");
    ext_a <= 8'h3D;
    repeat (20) @(posedge aclk);
    check(change_alert_n, 1'b0, "input change");
    xfer(1'b1, 2'h1, 8'h01, 8'h00, s);
    check(change_alert_n, 1'b0, "other port read");
    xfer(1'b1, 2'h1, 8'h00, 8'h00, s);
    check({s[7:0], change_alert_n}, 9'h07B, "port a read");
    // Mask first, then unmask once the pin has settled
    xfer(1'b0, 2'h1, 8'h06, 8'h01, s);
    ext_a <= 8'h3C;
    repeat (20) @(posedge aclk);
    xfer(1'b0, 2'h1, 8'h06, 8'h00, s);
    check(change_alert_n, 1'b1, "masked pin");
    ext_b <= 8'h3E;
    repeat (20) @(posedge aclk);
    xfer(1'b1, 2'h1, 8'h00, 8'h00, s);
    check(change_alert_n, 1'b0, "port b alert");
    xfer(1'b1, 2'h1, 8'h01, 8'h00, s);
    check({s[3:0], change_alert_n}, 5'h1D, "port b read");
    note("alert");
    ext_a <= 8'h3D;
    repeat (20) @(posedge aclk);
    axi_wr(`REG_BRST, 32'h1, r);
    repeat (20) @(posedge aclk);
    check({r, change_alert_n}, {`RESP_OKAY, 1'b0}, "bus reset");
    axi_wr(`REG_BRST, 32'h0, r);
    repeat (100) @(posedge aclk);
    xfer(1'b1, 2'h1, 8'h00, 8'h00, s);
    check(s[9:0], 10'h03D, "after bus reset");
    note("bus reset");
    xfer(1'b1, 2'h2, 8'h00, 8'h00, s);
    check(s[9], 1'b1, "foreign address");
    axi_rd(4'hC, s, r);
    check(r, `RESP_SLVERR, "unmapped");
    note("refusals");
    complete_run();
  end

  // Expected run is about 20000 cycles
  initial begin
    repeat (90000) @(posedge aclk);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule // i2c_io_expander_16bit_bench
